// ---- inc/nfc_consts.vh ----
// Offsets, fields, reset values and timing counts of the flash controller
`ifndef NFC_CONSTS_VH
`define NFC_CONSTS_VH
`define NFC_OFS_CTRL 12'h000
`define NFC_OFS_SLICE 12'h004
`define NFC_OFS_TOTAL 12'h008
`define NFC_OFS_TOT_ELAP 12'h00C
`define NFC_OFS_SLC_ELAP 12'h010
`define NFC_CTRL_SEL 0
`define NFC_CTRL_OP_LO 1
`define NFC_CTRL_OP_HI 2
`define NFC_CTRL_WAIT_LO 3
`define NFC_CTRL_WAIT_HI 4
`define NFC_CTRL_IHB0 5
`define NFC_CTRL_IHB1 6
`define NFC_CTRL_SUSP_EN 7
`define NFC_CTRL_SUSP_MODE 8
`define NFC_CTRL_IRQ_CLR 9
`define NFC_CTRL_RESUME 10
`define NFC_CTRL_ERS 16
`define NFC_CTRL_WRS 17
`define NFC_CTRL_RMIN 18
`define NFC_CTRL_SUSP_STAT 19
`define NFC_CTRL_IRQ 20
`define NFC_OP_READ 2'h0
`define NFC_OP_WRITE 2'h1
`define NFC_OP_PAGE 2'h2
`define NFC_OP_MASS 2'h3
`define NFC_WAIT_RST 2'h2
`define NFC_SLICE_RST 20'h0_03E7
`define NFC_TOTAL_RST 20'h0_4E20
`define NFC_TICK_NS 1000
`define NFC_CLK_NS 5
`define NFC_TICK_LAST 8'hC7
`define NFC_PROG_US 20'h0_0002
`define NFC_MASS_US 20'h0_0014
`define NFC_INFO_PAGE 8'h80
`endif

// ---- rtl/nfc_tick.v ----
// Microsecond tick generator
`include "nfc_consts.vh"
module nfc_tick (
	input wire pclk,
	input wire presetn,
	output reg tick
);
	reg [7:0] cnt_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
			tick <= 1'b0;
		end else if (cnt_reg == `NFC_TICK_LAST) begin
			cnt_reg <= 8'h00;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule

// ---- rtl/nfc_erase_timer.v ----
// Erase slice and total counters with suspend support
`include "nfc_consts.vh"
module nfc_erase_timer (
	input wire pclk,
	input wire presetn,
	input wire tick,
	input wire start,
	input wire run,
	input wire [19:0] slice_time,
	input wire [19:0] total_time,
	output reg [19:0] seg_cnt,
	output reg [19:0] tot_cnt,
	output reg first_tick_done,
	output wire seg_zero,
	output wire tot_zero
);
	assign seg_zero = (seg_cnt == 20'h0_0000);
	assign tot_zero = (tot_cnt == 20'h0_0000);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_cnt <= 20'h0_0000;
			tot_cnt <= 20'h0_0000;
			first_tick_done <= 1'b0;
		end else if (start) begin
			seg_cnt <= slice_time; // RULE_15
			tot_cnt <= total_time; // RULE_15
			first_tick_done <= 1'b0;
		end else if (run && tick) begin
			first_tick_done <= 1'b1; // RULE_16
			if (seg_zero) begin
				// Whole slice done: charge it to the total and reload
				tot_cnt <= (tot_cnt > slice_time) ? tot_cnt - slice_time : 20'h0_0000; // RULE_17
				seg_cnt <= slice_time; // RULE_17
			end else begin
				seg_cnt <= seg_cnt - 20'h0_0001;
			end
		end
	end
endmodule

// ---- rtl/nfc_top.v ----
// Embedded flash controller: AHB array access, APB registers, program and erase sequencing
//
// Functional notes
// RULE_01 - Software clears select and operation for read
// RULE_02 - Array reads stall by programmed wait cycles
// RULE_03 - Software picks wait cycles; default two
// RULE_04 - Fetch buffer serves other half next cycle
// RULE_05 - Fetch buffer enable per processor
// RULE_06 - Data reads always access array, select half
// RULE_07 - Write mode: select set, operation one
// RULE_08 - Unwritten half driven all ones
// RULE_09 - Completion interrupt held until software clear
// RULE_10 - Software writes only erased locations
// RULE_11 - Erase mode: operation two page, three mass
// RULE_12 - Dummy write starts erase of page
// RULE_13 - Info page address mass erases both
// RULE_14 - Other page read suspends erase when enabled
// RULE_15 - Erase start loads slice and total counters
// RULE_16 - No suspend during first microsecond tick
// RULE_17 - Mode 0 suspends at once, full slices charged
// RULE_18 - Erase done when total counter zero
// RULE_19 - Mode 1 stalls read until slice ends
// RULE_20 - Suspended flag shown; resume by writing one
// RULE_21 - Elapsed total and slice times readable
// RULE_22 - Erased page or no-suspend reads error
// RULE_23 - Software waits for idle status before changes
// RULE_24 - Mode sampled at transfer start; read-mode writes ignored
`include "nfc_consts.vh"
module nfc_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [18:0] haddr,
	input wire [31:0] hwdata,
	input wire hprot_instr,
	input wire hmaster,
	output reg [31:0] hrdata,
	output reg hready,
	output reg hresp,
	output reg irq,
	output reg [14:0] arr_addr,
	output reg arr_rd,
	output reg arr_prog,
	output reg arr_erase_page,
	output reg arr_erase_main,
	output reg arr_erase_info,
	output reg [63:0] arr_wdata,
	input wire [63:0] arr_rdata
);
	localparam ST_IDLE = 3'd0;
	localparam ST_WAIT = 3'd1;
	localparam ST_DATA = 3'd2;
	localparam ST_ERR1 = 3'd3;
	localparam ST_ERR2 = 3'd4;
	localparam ST_STALL = 3'd5;
	localparam ST_PROGW = 3'd6;
	localparam ER_IDLE = 2'd0;
	localparam ER_RUN = 2'd1;
	localparam ER_SUSP = 2'd2;
	localparam ER_MASS = 2'd3;
	reg sel_reg;
	reg [1:0] op_reg;
	reg [1:0] wait_reg;
	reg [1:0] ihb_en_reg;
	reg susp_en_reg;
	reg susp_mode_reg;
	reg [19:0] slice_reg;
	reg [19:0] total_reg;
	reg wrs_reg;
	reg [2:0] st_reg;
	reg [1:0] er_reg;
	reg [1:0] wcnt_reg;
	reg [19:0] busy_reg;
	reg [18:0] a_reg;
	reg a_instr_reg;
	reg a_mst_reg;
	reg [7:0] er_page_reg;
	reg [1:0] buf_vld_reg;
	reg [31:0] buf_dat_reg [0:1];
	reg [15:0] buf_tag_reg [0:1];
	reg ers_start;
	wire tick;
	wire [19:0] seg_cnt;
	wire [19:0] tot_cnt;
	wire first_done;
	wire seg_zero;
	wire tot_zero;
	wire ahb_req = hsel && htrans[1] && hready;
	wire apb_wr = psel && penable && pwrite;
	wire [7:0] req_page = haddr[18:11];
	wire [31:0] ctrl_rd = {11'h000, irq, er_reg == ER_SUSP, st_reg == ST_STALL, wrs_reg, er_reg != ER_IDLE, 7'h00,
		susp_mode_reg, susp_en_reg, ihb_en_reg, wait_reg, op_reg, sel_reg};
	wire can_susp = susp_en_reg && first_done; // RULE_14 RULE_16
	wire buf_hit = ihb_en_reg[hmaster] && buf_vld_reg[hmaster] && hprot_instr &&
		(buf_tag_reg[hmaster] == haddr[18:3]) && (haddr[2] != a_reg[2]); // RULE_04 RULE_05

	nfc_tick u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);
	nfc_erase_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.start(ers_start),
		.run(er_reg == ER_RUN),
		.slice_time(slice_reg),
		.total_time(total_reg),
		.seg_cnt(seg_cnt),
		.tot_cnt(tot_cnt),
		.first_tick_done(first_done),
		.seg_zero(seg_zero),
		.tot_zero(tot_zero)
	);

	// APB register slave, zero wait
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= 1'b0;
			op_reg <= `NFC_OP_READ;
			wait_reg <= `NFC_WAIT_RST; // RULE_03
			ihb_en_reg <= 2'b11;
			susp_en_reg <= 1'b0;
			susp_mode_reg <= 1'b0;
			slice_reg <= `NFC_SLICE_RST; // RULE_15
			total_reg <= `NFC_TOTAL_RST;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				pslverr <= paddr > `NFC_OFS_SLC_ELAP;
				case (paddr)
					`NFC_OFS_CTRL: prdata <= ctrl_rd;
					`NFC_OFS_SLICE: prdata <= {12'h000, slice_reg};
					`NFC_OFS_TOTAL: prdata <= {12'h000, total_reg};
					`NFC_OFS_TOT_ELAP: prdata <= {12'h000, total_reg - tot_cnt}; // RULE_21
					`NFC_OFS_SLC_ELAP: prdata <= {12'h000, slice_reg - seg_cnt}; // RULE_21
					default: prdata <= 32'h0000_0000;
				endcase
			end
			if (apb_wr && pready) begin
				case (paddr)
					`NFC_OFS_CTRL: begin
						sel_reg <= pwdata[`NFC_CTRL_SEL];
						op_reg <= pwdata[`NFC_CTRL_OP_HI:`NFC_CTRL_OP_LO];
						wait_reg <= pwdata[`NFC_CTRL_WAIT_HI:`NFC_CTRL_WAIT_LO];
						ihb_en_reg <= pwdata[`NFC_CTRL_IHB1:`NFC_CTRL_IHB0]; // RULE_05
						susp_en_reg <= pwdata[`NFC_CTRL_SUSP_EN];
						susp_mode_reg <= pwdata[`NFC_CTRL_SUSP_MODE];
					end
					`NFC_OFS_SLICE: slice_reg <= pwdata[19:0];
					`NFC_OFS_TOTAL: total_reg <= pwdata[19:0];
					default: sel_reg <= sel_reg;
				endcase
			end
		end
	end
	wire ctrl_wr = apb_wr && pready && (paddr == `NFC_OFS_CTRL);
	wire irq_clr = ctrl_wr && pwdata[`NFC_CTRL_IRQ_CLR];
	wire resume = ctrl_wr && pwdata[`NFC_CTRL_RESUME];
	wire prog_done = wrs_reg && tick && (busy_reg == 20'h0_0001);
	wire mass_done = (er_reg == ER_MASS) && tick && (busy_reg == 20'h0_0001);
	wire page_done = (er_reg == ER_RUN) && !ers_start && tot_zero && first_done; // RULE_18
	wire op_done = prog_done || mass_done || page_done;
	// Interrupt: completion set wins over clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (op_done) begin
			irq <= 1'b1; // RULE_09
		end else if (irq_clr) begin
			irq <= 1'b0; // RULE_09
		end
	end
	// AHB side and erase sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= ST_IDLE;
			er_reg <= ER_IDLE;
			wcnt_reg <= 2'h0;
			busy_reg <= 20'h0_0000;
			wrs_reg <= 1'b0;
			a_reg <= 19'h0_0000;
			a_instr_reg <= 1'b0;
			a_mst_reg <= 1'b0;
			er_page_reg <= 8'h00;
			buf_vld_reg <= 2'b00;
			buf_dat_reg[0] <= 32'h0000_0000;
			buf_dat_reg[1] <= 32'h0000_0000;
			buf_tag_reg[0] <= 16'h0000;
			buf_tag_reg[1] <= 16'h0000;
			ers_start <= 1'b0;
			hrdata <= 32'h0000_0000;
			hready <= 1'b1;
			hresp <= 1'b0;
			arr_addr <= 15'h0000;
			arr_rd <= 1'b0;
			arr_prog <= 1'b0;
			arr_erase_page <= 1'b0;
			arr_erase_main <= 1'b0;
			arr_erase_info <= 1'b0;
			arr_wdata <= {64{1'b1}};
		end else begin
			ers_start <= 1'b0;
			arr_rd <= 1'b0;
			arr_prog <= 1'b0;
			arr_erase_main <= 1'b0;
			arr_erase_info <= 1'b0;
			if (wrs_reg && tick) begin
				busy_reg <= busy_reg - 20'h0_0001;
				if (busy_reg == 20'h0_0001)
					wrs_reg <= 1'b0;
			end
			if (mass_done)
				er_reg <= ER_IDLE;
			else if (er_reg == ER_MASS && tick)
				busy_reg <= busy_reg - 20'h0_0001;
			if (page_done) begin
				er_reg <= ER_IDLE;
				arr_erase_page <= 1'b0;
			end
			if (er_reg == ER_SUSP && resume) begin
				er_reg <= ER_RUN; // RULE_20
				arr_erase_page <= 1'b1;
				arr_addr <= {er_page_reg[6:0], 8'h00};
			end
			case (st_reg)
				ST_IDLE: begin
					hresp <= 1'b0;
					hready <= 1'b1;
					if (ahb_req) begin
						a_reg <= haddr;
						a_instr_reg <= hprot_instr;
						a_mst_reg <= hmaster;
						if (hwrite) begin
							if (sel_reg && op_reg != `NFC_OP_READ && er_reg == ER_IDLE && !wrs_reg) begin
								hready <= 1'b0; // RULE_24
								st_reg <= ST_PROGW;
							end
						end else if (((er_reg == ER_RUN || er_reg == ER_SUSP) && req_page == er_page_reg) ||
							(er_reg == ER_RUN && !susp_en_reg)) begin
							hready <= 1'b0; // RULE_22
							st_reg <= ST_ERR1;
						end else if (er_reg == ER_RUN && can_susp && !susp_mode_reg) begin
							er_reg <= ER_SUSP; // RULE_14 RULE_17
							arr_erase_page <= 1'b0;
							hready <= 1'b0;
							st_reg <= ST_STALL;
						end else if (er_reg == ER_RUN || er_reg == ER_MASS || wrs_reg) begin
							hready <= 1'b0; // RULE_19
							st_reg <= ST_STALL;
						end else if (buf_hit) begin
							hready <= 1'b0;
							hrdata <= buf_dat_reg[hmaster]; // RULE_04
							st_reg <= ST_DATA;
						end else begin
							hready <= 1'b0;
							arr_addr <= haddr[17:3];
							arr_rd <= 1'b1; // RULE_02
							wcnt_reg <= wait_reg;
							st_reg <= ST_WAIT;
						end
					end
				end
				ST_STALL: begin
					if (er_reg == ER_RUN && susp_mode_reg && can_susp && seg_zero && tick) begin
						er_reg <= ER_SUSP; // RULE_19
						arr_erase_page <= 1'b0;
					end else if (er_reg == ER_RUN && can_susp && !susp_mode_reg) begin
						er_reg <= ER_SUSP;
						arr_erase_page <= 1'b0;
					end else if ((er_reg == ER_SUSP || er_reg == ER_IDLE) && !wrs_reg) begin
						arr_addr <= a_reg[17:3];
						arr_rd <= 1'b1;
						wcnt_reg <= wait_reg;
						st_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (wcnt_reg == 2'h0) begin
						hrdata <= a_reg[2] ? arr_rdata[63:32] : arr_rdata[31:0]; // RULE_06
						if (a_instr_reg) begin
							buf_vld_reg[a_mst_reg] <= 1'b1; // RULE_04
							buf_tag_reg[a_mst_reg] <= a_reg[18:3];
							buf_dat_reg[a_mst_reg] <= a_reg[2] ? arr_rdata[31:0] : arr_rdata[63:32];
						end
						st_reg <= ST_DATA;
					end else begin
						wcnt_reg <= wcnt_reg - 2'h1; // RULE_02
					end
				end
				ST_DATA, ST_ERR2: begin
					hready <= 1'b1;
					st_reg <= ST_IDLE;
				end
				ST_ERR1: begin
					hresp <= 1'b1; // RULE_22
					st_reg <= ST_ERR2;
				end
				ST_PROGW: begin
					buf_vld_reg <= 2'b00;
					hready <= 1'b1;
					st_reg <= ST_IDLE;
					arr_addr <= a_reg[17:3];
					if (op_reg == `NFC_OP_WRITE) begin
						arr_prog <= 1'b1;
						arr_wdata <= a_reg[2] ? {hwdata, 32'hFFFF_FFFF} : {32'hFFFF_FFFF, hwdata}; // RULE_08
						wrs_reg <= 1'b1;
						busy_reg <= `NFC_PROG_US;
					end else if (op_reg == `NFC_OP_PAGE) begin
						er_page_reg <= a_reg[18:11]; // RULE_12
						arr_erase_page <= 1'b1;
						er_reg <= ER_RUN;
						ers_start <= 1'b1;
					end else begin
						arr_erase_main <= 1'b1; // RULE_13
						arr_erase_info <= (a_reg[18:11] == `NFC_INFO_PAGE); // RULE_13
						er_reg <= ER_MASS;
						busy_reg <= `NFC_MASS_US;
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end
endmodule

// ---- dv/nfc_top_props.sv ----
// Checker of the flash controller port behaviour
module nfc_top_props (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic pready,
	input logic pslverr,
	input logic hready,
	input logic hresp,
	input logic irq,
	input logic arr_rd,
	input logic arr_prog,
	input logic arr_erase_page,
	input logic arr_erase_main,
	input logic arr_erase_info,
	input logic [63:0] arr_wdata
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire clr = psel && penable && pwrite && pready && paddr == 12'h000 && pwdata[9];
	property p_rd_stall; arr_rd |-> !hready; endproperty
	a_rd_stall: assert property (p_rd_stall) else $error("array read without stall");
	property p_rd_wait; arr_rd |-> ##[1:5] hready; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read stall too long");
	property p_half; arr_prog |-> arr_wdata[63:32] == 32'hFFFF_FFFF || arr_wdata[31:0] == 32'hFFFF_FFFF; endproperty
	a_half: assert property (p_half) else $error("unwritten half not all ones");
	property p_irq_hold; irq && !clr |=> irq; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear");
	property p_irq_prog; arr_prog |-> ##[1:1000] irq; endproperty
	a_irq_prog: assert property (p_irq_prog) else $error("no irq after program");
	property p_info_main; arr_erase_info |-> arr_erase_main; endproperty
	a_info_main: assert property (p_info_main) else $error("info erase without main");
	property p_apb_err; psel && penable && paddr > 12'h010 |-> pslverr && pready; endproperty
	a_apb_err: assert property (p_apb_err) else $error("unmapped access not refused");
	property p_err_seq; $rose(hresp) |-> !hready ##1 hready; endproperty
	a_err_seq: assert property (p_err_seq) else $error("error response shape");
	c_prog: cover property (arr_prog);
	c_erase: cover property ($rose(arr_erase_page));
	c_err: cover property ($rose(hresp));
endmodule

bind nfc_top nfc_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .hready(hready),
	.hresp(hresp), .irq(irq), .arr_rd(arr_rd), .arr_prog(arr_prog), .arr_erase_page(arr_erase_page),
	.arr_erase_main(arr_erase_main), .arr_erase_info(arr_erase_info), .arr_wdata(arr_wdata));

// ---- dv/nfc_array_model.sv ----
// Behavioural flash array behind the controller
module nfc_array_model (
	input logic pclk,
	input logic [14:0] arr_addr,
	input logic arr_rd,
	input logic arr_prog,
	input logic arr_erase_page,
	input logic arr_erase_main,
	input logic arr_erase_info,
	input logic [63:0] arr_wdata,
	output logic [63:0] arr_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] mem [logic [14:0]];
	logic ers_q = 1'b0;
	initial arr_rdata = 64'h0000_0000_0000_0000;
	// Read word settles mid-cycle so it is valid at the first edge after the read strobe
	always @(negedge pclk) begin
		if (arr_rd) begin
			arr_rdata <= mem.exists(arr_addr) ? mem[arr_addr] : 64'hFFFF_FFFF_FFFF_FFFF;
		end
	end
	always @(posedge pclk) begin
		ers_q <= arr_erase_page;
		if (arr_prog) begin
			mem[arr_addr] = (mem.exists(arr_addr) ? mem[arr_addr] : 64'hFFFF_FFFF_FFFF_FFFF) & arr_wdata;
		end
		if (arr_erase_main || arr_erase_info) begin
			mem.delete();
		end
		if (arr_erase_page && !ers_q) begin
			for (int i = 0; i < 256; i++) begin
				if (mem.exists({arr_addr[14:8], i[7:0]})) mem.delete({arr_addr[14:8], i[7:0]});
			end
		end
	end
endmodule

// ---- dv/nfc_top_bench.sv ----
// Self-checking bench of the flash controller
module nfc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic hsel = 0, hwrite = 0, hprot_instr = 0, hmaster = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, hwdata = 32'h0000_0000, rd, ctrl;
	logic [1:0] htrans = 2'b00;
	logic [18:0] haddr = 19'h0_0000;
	logic err, perr;
	wire [31:0] prdata, hrdata;
	wire pready, pslverr, hready, hresp, irq, arr_rd, arr_prog, ep, em, ei;
	wire [14:0] arr_addr;
	wire [63:0] arr_wdata, arr_rdata;
	int n_errors = 0, n_checks = 0, cyc = 0, n;
	always #2.5 pclk = ~pclk;
	nfc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hsel(hsel), .htrans(htrans),
		.hwrite(hwrite), .haddr(haddr), .hwdata(hwdata), .hprot_instr(hprot_instr), .hmaster(hmaster),
		.hrdata(hrdata), .hready(hready), .hresp(hresp), .irq(irq), .arr_addr(arr_addr), .arr_rd(arr_rd),
		.arr_prog(arr_prog), .arr_erase_page(ep), .arr_erase_main(em), .arr_erase_info(ei),
		.arr_wdata(arr_wdata), .arr_rdata(arr_rdata));
	nfc_array_model u_array (.pclk(pclk), .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_prog(arr_prog),
		.arr_erase_page(ep), .arr_erase_main(em), .arr_erase_info(ei), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));
	task results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			results;
		end
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task setc(input logic [31:0] v);
		ctrl = v;
		apb(1, 12'h000, v);
	endtask
	task ahb(input logic w, input logic [18:0] a, input logic [31:0] d, input logic ins);
		@(posedge pclk);
		hsel <= 1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		hprot_instr <= ins;
		@(posedge pclk);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		n = 0;
		err = 0;
		do begin
			@(posedge pclk);
			n++;
			err |= hresp;
		end while (hready !== 1'b1 && n < 5000);
		rd = hrdata;
	endtask
	task wait_irq;
		int i;
		i = 0;
		while (irq !== 1'b1 && i < 5000) begin
			@(posedge pclk);
			i++;
		end
		chk("irq", 1, irq);
		apb(1, 12'h000, ctrl | 32'h0000_0200);
		@(posedge pclk);
		chk("irq clear", 0, irq);
	endtask
	task t_regs;
		apb(0, 12'h000, 0);
		chk("wait", 2, rd[4:3]);
		apb(0, 12'h004, 0);
		chk("slice", 999, rd);
		apb(0, 12'h008, 0);
		chk("total", 20000, rd);
		apb(0, 12'h014, 0);
		chk("unmapped", 0, rd);
		chk("slverr", 1, perr);
	endtask
	task t_write;
		setc(32'h0000_0003);
		ahb(1, 19'h0_0104, 32'h1234_5678, 0);
		wait_irq;
		for (int w = 0; w < 4; w++) begin
			setc(w << 3);
			ahb(0, 19'h0_0104, 0, 0);
			chk("data", 32'h1234_5678, rd);
			chk("latency", 3 + w, n);
		end
		ahb(0, 19'h0_0100, 0, 0);
		chk("other half", 32'hFFFF_FFFF, rd);
		ahb(1, 19'h0_0200, 32'h0000_0000, 0);
		chk("read mode write", 0, irq);
		ahb(0, 19'h0_0200, 0, 0);
		chk("untouched", 32'hFFFF_FFFF, rd);
	endtask
	task t_fetch;
		setc(32'h0000_0038);
		ahb(0, 19'h0_0100, 0, 1);
		chk("fetch miss", 6, n);
		ahb(0, 19'h0_0104, 0, 1);
		chk("fetch hit", 2, n);
		chk("hit data", 32'h1234_5678, rd);
		hmaster <= 1;
		ahb(0, 19'h0_0100, 0, 1);
		ahb(0, 19'h0_0104, 0, 1);
		chk("buffer off", 6, n);
		hmaster <= 0;
	endtask
	task t_erase;
		apb(1, 12'h004, 2);
		apb(1, 12'h008, 5);
		setc(32'h0000_0005);
		ahb(1, 19'h0_0104, 0, 0);
		ahb(0, 19'h0_0800, 0, 0);
		chk("no suspend err", 1, err);
		wait_irq;
		setc(0);
		ahb(0, 19'h0_0104, 0, 0);
		chk("erased", 32'hFFFF_FFFF, rd);
	endtask
	task t_susp;
		for (int m = 0; m < 2; m++) begin
			setc(32'h0000_0085 | (m << 8));
			ahb(1, 19'h0_0800, 0, 0);
			repeat (300) @(posedge pclk);
			ahb(0, 19'h0_0104, 0, 0);
			chk("suspend read", 0, err);
			if (m == 1) chk("slice stall", 1, n > 5);
			apb(0, 12'h000, 0);
			chk("suspended", 1, rd[19]);
			if (m == 1) begin
				apb(0, 12'h00C, 0);
				chk("total elapsed", 2, rd);
				apb(0, 12'h010, 0);
				chk("slice elapsed", 0, rd);
			end
			ahb(0, 19'h0_0800, 0, 0);
			chk("same page err", 1, err);
			apb(1, 12'h000, ctrl | 32'h0000_0400);
			wait_irq;
			apb(0, 12'h000, 0);
			chk("resumed", 0, rd[19]);
		end
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_write;
		t_fetch;
		t_erase;
		t_susp;
		setc(32'h0000_0007);
		ahb(1, 19'h4_0000, 0, 0);
		wait_irq;
		results;
	end
endmodule
